// ===== oag_operand_address_generator.sv
/*
 * Operand address generator: forms effective addresses for data access
 * and branch targets for relative jumps, reading page-zero pointers and
 * displacements from data memory when the mode needs them.
 * Assumes the decoder holds its request inputs stable while START pulses,
 * and that memory answers a read with RD_VALID one or more cycles later.
 */
// Operation
// - Indexed long offset adds the two-byte offset to the index register.
// - Sums beyond 0FFFFh keep only their low 16 bits and wrap through zero.
// - Relative direct adds the signed operand byte to the next address.
// - Relative modes are honoured only on jump instructions.
// - Relative indirect reads a page-zero displacement and adds it signed.
// - The relative indirect displacement is read from page zero.
// - Indirect short uses the page-zero pointer byte as the address.
// - Indirect long reads a 16-bit address from a page-zero pointer pair.
// - Indexed indirect short adds the pointer byte to the index register.
// - Indexed indirect long adds the pointer word to the index register.
// - The alternate index register is used when its prefix is present.
// - The first byte of any two-byte quantity is the most significant.
`timescale 1ns/1ps

module oag_operand_address_generator
	import oag_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic START,
	input wire logic [2:0] MODE,
	input wire logic [7:0] PREFIX,
	input wire logic IS_JUMP,
	input wire logic [7:0] OPERAND_HI,
	input wire logic [7:0] OPERAND_LO,
	input wire logic [15:0] NEXT_PC,
	input wire logic [7:0] INDEX_PRIMARY,
	input wire logic [7:0] INDEX_ALTERNATE,
	input wire logic [7:0] RD_DATA,
	input wire logic RD_VALID,
	output logic RD_REQ,
	output logic [15:0] RD_ADDR,
	output logic EA_VALID,
	output logic [15:0] EA,
	output logic TARGET_VALID,
	output logic [15:0] TARGET,
	output logic MODE_ERROR,
	output logic BUSY
);

	typedef struct packed {
		oag_state_e st;
		oag_mode_e mode;
		logic [15:0] base;
		logic [7:0] index;
		logic [7:0] ptr;
		logic [7:0] hi;
		logic rd_req;
		logic [15:0] rd_addr;
		logic ea_valid;
		logic [15:0] ea;
		logic tgt_valid;
		logic [15:0] tgt;
		logic mode_error;
		logic busy;
	} oag_state_s;

	oag_state_s r;
	oag_state_s next_r;
	logic [7:0] idx_sel;
	logic [15:0] sext_disp;

	// Alternate index is chosen by its own prefix or the combined one
	assign idx_sel = (PREFIX == OAG_ALT_INDEX_PREFIX_BYTE ||
		PREFIX == OAG_BOTH_PREFIX_BYTE) ? INDEX_ALTERNATE
		: INDEX_PRIMARY;

	// Sign extension of a displacement byte coming back from memory
	assign sext_disp = {{8{RD_DATA[7]}}, RD_DATA};

	// Sequencer; address sums are 16 bits wide and the pointer step 8 bits, so carries out simply drop
	always_comb begin
		next_r = r;
		next_r.rd_req = 1'b0;
		next_r.ea_valid = 1'b0;
		next_r.tgt_valid = 1'b0;
		next_r.mode_error = 1'b0;
		case (r.st)
			OAG_ST_IDLE: begin
				if (START) begin
					next_r.mode = oag_mode_e'(MODE);
					next_r.index = idx_sel;
					next_r.base = NEXT_PC;
					next_r.ptr = OPERAND_LO;
					case (oag_mode_e'(MODE))
						OAG_MODE_IDX_LONG: begin
							// MSB first, index zero-extended, wraps at 16 bits
							next_r.ea = {OPERAND_HI, OPERAND_LO}
								+ {8'h00, idx_sel};
							next_r.ea_valid = 1'b1;
						end
						OAG_MODE_REL_DIR: begin
							if (IS_JUMP) begin
								next_r.tgt = NEXT_PC
									+ {{8{OPERAND_LO[7]}}, OPERAND_LO};
								next_r.tgt_valid = 1'b1;
							end else begin
								next_r.mode_error = 1'b1;
							end
						end
						OAG_MODE_REL_IND: begin
							if (IS_JUMP) begin
								// Displacement byte lives in page zero
								next_r.rd_addr = {8'h00, OPERAND_LO};
								next_r.rd_req = 1'b1;
								next_r.st = OAG_ST_WAIT_LO;
							end else begin
								next_r.mode_error = 1'b1;
							end
						end
						OAG_MODE_IND_SHORT, OAG_MODE_IDX_IND_SHORT: begin
							next_r.rd_addr = {8'h00, OPERAND_LO};
							next_r.rd_req = 1'b1;
							next_r.st = OAG_ST_WAIT_LO;
						end
						OAG_MODE_IND_LONG, OAG_MODE_IDX_IND_LONG: begin
							// Pointer pair sits in page zero, high byte first
							next_r.rd_addr = {8'h00, OPERAND_LO};
							next_r.rd_req = 1'b1;
							next_r.st = OAG_ST_WAIT_HI;
						end
						default: begin
							next_r.mode_error = 1'b1;
						end
					endcase
				end
			end
			OAG_ST_WAIT_HI: begin
				if (RD_VALID) begin
					next_r.hi = RD_DATA;
					next_r.st = OAG_ST_RD_LO;
				end
			end
			OAG_ST_RD_LO: begin
				// Second pointer byte; a pointer at 0FFh wraps to 00h
				next_r.rd_addr = {8'h00, r.ptr + 8'h01};
				next_r.rd_req = 1'b1;
				next_r.st = OAG_ST_WAIT_LO;
			end
			OAG_ST_WAIT_LO: begin
				if (RD_VALID) begin
					next_r.st = OAG_ST_IDLE;
					case (r.mode)
						OAG_MODE_REL_IND: begin
							next_r.tgt = r.base + sext_disp;
							next_r.tgt_valid = 1'b1;
						end
						OAG_MODE_IND_SHORT: begin
							next_r.ea = {8'h00, RD_DATA};
							next_r.ea_valid = 1'b1;
						end
						OAG_MODE_IDX_IND_SHORT: begin
							// Reaches at most 1FEh
							next_r.ea = {8'h00, RD_DATA}
								+ {8'h00, r.index};
							next_r.ea_valid = 1'b1;
						end
						OAG_MODE_IND_LONG: begin
							next_r.ea = {r.hi, RD_DATA};
							next_r.ea_valid = 1'b1;
						end
						OAG_MODE_IDX_IND_LONG: begin
							next_r.ea = {r.hi, RD_DATA}
								+ {8'h00, r.index};
							next_r.ea_valid = 1'b1;
						end
						default: begin
							next_r.mode_error = 1'b1;
						end
					endcase
				end
			end
			default: begin
				next_r.st = OAG_ST_IDLE;
			end
		endcase
		// Busy is registered so the output needs no decode after the flops
		next_r.busy = (next_r.st != OAG_ST_IDLE);
	end

	// State register; reset loads constants only
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			r <= '{st: OAG_ST_IDLE, mode: OAG_MODE_IDX_LONG, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from the state flip-flops
	assign RD_REQ = r.rd_req;
	assign RD_ADDR = r.rd_addr;
	assign EA_VALID = r.ea_valid;
	assign EA = r.ea;
	assign TARGET_VALID = r.tgt_valid;
	assign TARGET = r.tgt;
	assign MODE_ERROR = r.mode_error;
	assign BUSY = r.busy;

	// Checks
	property p_idx_long;
		@(posedge CLK) disable iff (RST)
		(START && !BUSY && MODE == 3'h0) |=> EA_VALID &&
			EA == 16'({$past(OPERAND_HI), $past(OPERAND_LO)}
			+ {8'h00, $past(idx_sel)});
	endproperty
	a_idx_long: assert property (p_idx_long)
		else $error("idx long ea");

	property p_wrap;
		@(posedge CLK) disable iff (RST)
		(START && !BUSY && MODE == 3'h0 && OPERAND_HI == 8'hff
			&& OPERAND_LO == 8'hc2 && idx_sel == 8'h83) |=> EA == 16'h0045;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("no wrap");

	property p_rel_dir;
		@(posedge CLK) disable iff (RST)
		(START && !BUSY && MODE == 3'h1 && IS_JUMP) |=> TARGET_VALID &&
			TARGET == 16'($past(NEXT_PC)
			+ {{8{$past(OPERAND_LO[7])}}, $past(OPERAND_LO)});
	endproperty
	a_rel_dir: assert property (p_rel_dir)
		else $error("rel target");

	property p_rel_nojump;
		@(posedge CLK) disable iff (RST)
		(START && !BUSY && (MODE == 3'h1 || MODE == 3'h2) && !IS_JUMP)
			|=> MODE_ERROR && !RD_REQ && !TARGET_VALID;
	endproperty
	a_rel_nojump: assert property (p_rel_nojump)
		else $error("rel non-jump");

	property p_page_zero;
		@(posedge CLK) disable iff (RST)
		RD_REQ |-> RD_ADDR[15:8] == 8'h00;
	endproperty
	a_page_zero: assert property (p_page_zero)
		else $error("ptr off page 0");

	property p_ind_short;
		@(posedge CLK) disable iff (RST)
		(r.st == OAG_ST_WAIT_LO && r.mode == OAG_MODE_IND_SHORT && RD_VALID)
			|=> EA_VALID && EA == {8'h00, $past(RD_DATA)};
	endproperty
	a_ind_short: assert property (p_ind_short)
		else $error("ind short");

	property p_long_order;
		@(posedge CLK) disable iff (RST)
		(r.st == OAG_ST_RD_LO) |=> RD_REQ &&
			RD_ADDR == {8'h00, 8'($past(r.ptr) + 8'h01)};
	endproperty
	a_long_order: assert property (p_long_order)
		else $error("lo ptr addr");

	property p_idx_ind_short;
		@(posedge CLK) disable iff (RST)
		(r.st == OAG_ST_WAIT_LO && r.mode == OAG_MODE_IDX_IND_SHORT
			&& RD_VALID) |=> EA_VALID && EA <= 16'h01fe
			&& EA == 16'({8'h00, $past(RD_DATA)} + {8'h00, $past(r.index)});
	endproperty
	a_idx_ind_short: assert property (p_idx_ind_short)
		else $error("range");

	property p_idx_ind_long;
		@(posedge CLK) disable iff (RST)
		(r.st == OAG_ST_WAIT_LO && r.mode == OAG_MODE_IDX_IND_LONG && RD_VALID)
			|=> EA == 16'({$past(r.hi), $past(RD_DATA)}
			+ {8'h00, $past(r.index)});
	endproperty
	a_idx_ind_long: assert property (p_idx_ind_long)
		else $error("idx ind long");

	// Judged against the alternate pin itself, not the internal select
	property p_alt_index;
		@(posedge CLK) disable iff (RST)
		(START && !BUSY && MODE == 3'h0
			&& (PREFIX == OAG_ALT_INDEX_PREFIX_BYTE
			|| PREFIX == OAG_BOTH_PREFIX_BYTE))
			|=> EA == 16'({$past(OPERAND_HI), $past(OPERAND_LO)}
			+ {8'h00, $past(INDEX_ALTERNATE)});
	endproperty
	a_alt_index: assert property (p_alt_index)
		else $error("alternate index");

	property p_rel_ind;
		@(posedge CLK) disable iff (RST)
		(r.st == OAG_ST_WAIT_LO && r.mode == OAG_MODE_REL_IND && RD_VALID)
			|=> TARGET_VALID && TARGET == 16'($past(r.base)
			+ {{8{$past(RD_DATA[7])}}, $past(RD_DATA)});
	endproperty
	a_rel_ind: assert property (p_rel_ind)
		else $error("rel ind target");

	property p_msb_first;
		@(posedge CLK) disable iff (RST)
		(r.st == OAG_ST_WAIT_HI && RD_VALID)
			|=> r.st == OAG_ST_RD_LO && r.hi == $past(RD_DATA);
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("first byte not high");

	// A result never overlaps a pending read, so the address is final
	property p_ea_done;
		@(posedge CLK) disable iff (RST)
		(EA_VALID || TARGET_VALID) |-> !BUSY && !RD_REQ;
	endproperty
	a_ea_done: assert property (p_ea_done)
		else $error("result while busy");

endmodule : oag_operand_address_generator

// ===== oag_pkg.sv
/*
 * Package for the operand address generator: addressing mode codes,
 * prefix bytes and the state encoding of the generator's sequencer.
 * Assumes one core clock and a byte-wide data memory with 16-bit address.
 */
package oag_pkg;

	// Prefix bytes seen before the opcode
	localparam logic [7:0] OAG_INDIRECT_PREFIX_BYTE = 8'h92;
	localparam logic [7:0] OAG_ALT_INDEX_PREFIX_BYTE = 8'h90;
	localparam logic [7:0] OAG_BOTH_PREFIX_BYTE = 8'h91;

	// Address space limits
	localparam int OAG_ADDR_W = 16;
	localparam logic [15:0] OAG_PAGE_ZERO_TOP = 16'h00ff;

	// Addressing modes decoded upstream
	typedef enum logic [2:0] {
		OAG_MODE_IDX_LONG = 3'h0,
		OAG_MODE_REL_DIR = 3'h1,
		OAG_MODE_REL_IND = 3'h2,
		OAG_MODE_IND_SHORT = 3'h3,
		OAG_MODE_IND_LONG = 3'h4,
		OAG_MODE_IDX_IND_SHORT = 3'h5,
		OAG_MODE_IDX_IND_LONG = 3'h6
	} oag_mode_e;

	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		OAG_ST_IDLE = 5'b00001,
		OAG_ST_RD_HI = 5'b00010,
		OAG_ST_WAIT_HI = 5'b00100,
		OAG_ST_RD_LO = 5'b01000,
		OAG_ST_WAIT_LO = 5'b10000
	} oag_state_e;

endpackage : oag_pkg

// ===== oag_mem_model.sv
/*
 * Data memory model for the address generator bench: answers RD_REQ with
 * RD_VALID after a short or long wait and serves page-zero bytes.
 * Assumes one request at a time; the bench fills mem before a request.
 */
`timescale 1ns/1ps

module oag_mem_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic rd_req,
	input wire logic [15:0] rd_addr,
	input wire logic slow,
	output logic [7:0] rd_data,
	output logic rd_valid
);
	logic [7:0] mem [0:255];
	logic [7:0] addr;
	logic [2:0] wait_cnt;
	logic pend;

	// Read data is only good with rd_valid; otherwise it flips every cycle
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pend <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
		end else begin
			rd_valid <= 1'b0;
			rd_data <= ~rd_data;
			if (rd_req) begin
				pend <= 1'b1;
				addr <= rd_addr[7:0];
				wait_cnt <= slow ? 3'h3 : 3'h0;
			end else if (pend && wait_cnt != 3'h0) begin
				wait_cnt <= wait_cnt - 3'h1;
			end else if (pend) begin
				pend <= 1'b0;
				rd_valid <= 1'b1;
				rd_data <= mem[addr];
			end
		end
	end
endmodule : oag_mem_model

// ===== operand_address_generator_tb.sv
/*
 * Self-checking bench for the operand address generator: one task per
 * group of addressing modes plus a busy test, results judged against hand-worked addresses.
 * Assumes the memory model above stands on the read port.
 */
`timescale 1ns/1ps

module operand_address_generator_tb;
	import oag_pkg::*;
	logic CLK = 1'b0, RST = 1'b1, START = 1'b0, IS_JUMP = 1'b0;
	logic [2:0] MODE = 3'h0;
	logic [7:0] PREFIX = 8'h00, OPERAND_HI = 8'h00, OPERAND_LO = 8'h00;
	logic [7:0] INDEX_PRIMARY = 8'h00, INDEX_ALTERNATE = 8'h00, RD_DATA;
	logic [15:0] NEXT_PC = 16'h0000, RD_ADDR, EA, TARGET, last_addr;
	logic RD_VALID, RD_REQ, EA_VALID, TARGET_VALID, MODE_ERROR, BUSY;
	logic slow = 1'b0;
	int mismatches = 0, samples_checked = 0;

	oag_operand_address_generator oag_operand_address_generator_i (
		.CLK(CLK), .RST(RST), .START(START), .MODE(MODE), .PREFIX(PREFIX),
		.IS_JUMP(IS_JUMP), .OPERAND_HI(OPERAND_HI), .OPERAND_LO(OPERAND_LO),
		.NEXT_PC(NEXT_PC), .INDEX_PRIMARY(INDEX_PRIMARY),
		.INDEX_ALTERNATE(INDEX_ALTERNATE), .RD_DATA(RD_DATA),
		.RD_VALID(RD_VALID), .RD_REQ(RD_REQ), .RD_ADDR(RD_ADDR),
		.EA_VALID(EA_VALID), .EA(EA), .TARGET_VALID(TARGET_VALID),
		.TARGET(TARGET), .MODE_ERROR(MODE_ERROR), .BUSY(BUSY));
	oag_mem_model oag_mem_model_i (.clk(CLK), .rst(RST), .rd_req(RD_REQ),
		.rd_addr(RD_ADDR), .slow(slow), .rd_data(RD_DATA),
		.rd_valid(RD_VALID));

	always #5 CLK = ~CLK;

	// Remember the last address read so pointer fetches can be judged
	always @(posedge CLK) begin
		if (RD_REQ === 1'b1) last_addr <= RD_ADDR;
	end

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One request, then wait a bounded time for any result pulse
	task automatic op(input logic [2:0] m, input logic [7:0] p,
		input logic j, input logic [15:0] opnd, input logic [15:0] pc,
		input logic [7:0] x, input logic [7:0] y);
		int n;
		n = 0;
		START <= 1'b1;
		MODE <= m;
		PREFIX <= p;
		IS_JUMP <= j;
		{OPERAND_HI, OPERAND_LO} <= opnd;
		NEXT_PC <= pc;
		INDEX_PRIMARY <= x;
		INDEX_ALTERNATE <= y;
		@(posedge CLK);
		START <= 1'b0;
		while (!(EA_VALID === 1'b1 || TARGET_VALID === 1'b1 ||
			MODE_ERROR === 1'b1) && n < 40) begin
			@(posedge CLK);
			n++;
		end
		if (n == 40) check("result", 16'h0000, 16'h0001);
	endtask : op

	task automatic t_idx_long;
		op(3'h0, 8'h00, 1'b0, 16'hffc2, 16'h0000, 8'h83, 8'h00);
		check("ea wrap", EA, 16'h0045);
		op(3'h0, 8'h90, 1'b0, 16'h4523, 16'h0000, 8'h00, 8'h64);
		check("ea alt", EA, 16'h4587);
		op(3'h0, 8'h00, 1'b0, 16'h0001, 16'h0000, 8'hff, 8'h00);
		check("ea zext", EA, 16'h0100);
	endtask : t_idx_long

	task automatic t_rel;
		op(3'h1, 8'h00, 1'b1, 16'h00ef, 16'h1202, 8'h00, 8'h00);
		check("target back", TARGET, 16'h11f1);
		op(3'h1, 8'h00, 1'b1, 16'h007f, 16'h1202, 8'h00, 8'h00);
		check("target fwd", TARGET, 16'h1281);
		op(3'h1, 8'h00, 1'b0, 16'h0010, 16'h1202, 8'h00, 8'h00);
		check("no jump", {15'h0000, MODE_ERROR}, 16'h0001);
		op(3'h2, 8'h92, 1'b0, 16'h0058, 16'h1203, 8'h00, 8'h00);
		check("ind no jump", {15'h0000, MODE_ERROR}, 16'h0001);
		op(3'h7, 8'h00, 1'b1, 16'h0010, 16'h1202, 8'h00, 8'h00);
		check("bad mode", {15'h0000, MODE_ERROR}, 16'h0001);
	endtask : t_rel

	task automatic t_rel_ind;
		oag_mem_model_i.mem[8'h58] = 8'hee;
		slow = 1'b1;
		op(3'h2, 8'h92, 1'b1, 16'h0058, 16'h1203, 8'h00, 8'h00);
		slow = 1'b0;
		check("target ind", TARGET, 16'h11f1);
		check("displ addr", last_addr, 16'h0058);
	endtask : t_rel_ind

	task automatic t_ind;
		oag_mem_model_i.mem[8'h23] = 8'h79;
		oag_mem_model_i.mem[8'h24] = 8'h54;
		op(3'h3, 8'h92, 1'b0, 16'h0023, 16'h0000, 8'h00, 8'h00);
		check("ea short", EA, 16'h0079);
		op(3'h4, 8'h92, 1'b0, 16'h0023, 16'h0000, 8'h00, 8'h00);
		check("ea long", EA, 16'h7954);
		check("ptr lo", last_addr, 16'h0024);
		oag_mem_model_i.mem[8'hff] = 8'h12;
		oag_mem_model_i.mem[8'h00] = 8'h34;
		op(3'h4, 8'h92, 1'b0, 16'h00ff, 16'h0000, 8'h00, 8'h00);
		check("ea pz wrap", EA, 16'h1234);
		check("ptr wrap", last_addr, 16'h0000);
	endtask : t_ind

	// A request while busy is dropped; BUSY stands until the result
	task automatic t_busy;
		int n;
		n = 0;
		oag_mem_model_i.mem[8'h40] = 8'h21;
		slow = 1'b1;
		START <= 1'b1;
		MODE <= 3'h3;
		PREFIX <= 8'h00;
		{OPERAND_HI, OPERAND_LO} <= 16'h0040;
		@(posedge CLK);
		// Held START now meets BUSY and must be ignored
		MODE <= 3'h0;
		@(posedge CLK);
		START <= 1'b0;
		check("busy", {15'h0000, BUSY}, 16'h0001);
		while (EA_VALID !== 1'b1 && n < 40) begin
			@(posedge CLK);
			n++;
		end
		slow = 1'b0;
		check("ea held off", EA, 16'h0021);
		check("busy end", {15'h0000, BUSY}, 16'h0000);
	endtask : t_busy

	task automatic t_idx_ind;
		oag_mem_model_i.mem[8'h23] = 8'hff;
		op(3'h5, 8'h92, 1'b0, 16'h0023, 16'h0000, 8'hff, 8'h00);
		check("ea idx short", EA, 16'h01fe);
		oag_mem_model_i.mem[8'h23] = 8'h79;
		oag_mem_model_i.mem[8'h24] = 8'h45;
		op(3'h6, 8'h91, 1'b0, 16'h0023, 16'h0000, 8'h00, 8'h05);
		check("ea idx long", EA, 16'h794a);
	endtask : t_idx_ind

	task automatic give_verdict;
		if (mismatches == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	// Main sequence
	initial begin
		repeat (5) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		t_idx_long();
		t_rel();
		t_rel_ind();
		t_ind();
		t_busy();
		t_idx_ind();
		give_verdict();
	end

	// Watchdog; the whole run needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge CLK);
		mismatches++;
		give_verdict();
	end
endmodule : operand_address_generator_tb
